// File: hdl/ults_top.sv
// User line outputs, shutdown gating and trip level source selection
module ults_top (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire ults_pkg::ults_cmd_t i_serial_cmd,
	input wire ults_pkg::ults_cmd_t i_net_cmd,
	input wire ults_pkg::ults_jumpers_t i_jumpers,
	input wire logic i_power_on_remote,
	input wire logic i_local_button,
	input wire logic i_local_lockout,
	input wire logic [ults_pkg::TRIP_W-1:0] i_rated_level,
	input wire logic [ults_pkg::TRIP_W-1:0] i_panel_trip_level,
	input wire logic [ults_pkg::FAULT_W-1:0] i_fault_bits,
	input wire logic i_shutdown_pin,
	output logic o_remote_mode,
	output logic [ults_pkg::TRIP_W-1:0] o_over_voltage_trip,
	output logic o_trip_from_software,
	output logic o_supply_output_en,
	output logic o_output_cmd_on,
	output ults_pkg::ults_lines_t o_lines_on,
	output ults_pkg::ults_lines_t o_lines_oe
);

	// ****************************************
	// Command merge
	// ****************************************
	ults_pkg::ults_cmd_t cmd;

	always_comb begin
		// Serial wins if both arrive in one cycle; the net command of that cycle is dropped
		cmd = i_serial_cmd.valid ? i_serial_cmd : i_net_cmd;
	end

	// ****************************************
	// Shutdown synchroniser
	// ****************************************
	logic [1:0] sync_q;
	logic [1:0] sync_d;

	always_comb begin
		sync_d = {sync_q[0], i_shutdown_pin};
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_q <= ults_pkg::SYNC_RST;
		end else begin
			sync_q <= sync_d;
		end
	end

	// ****************************************
	// Command decode
	// ****************************************
	ults_pkg::ults_mode_t mode_q;
	logic ren_q;
	logic por_done_q;
	logic por_done_d;
	logic cmd_live;
	logic power_on;
	logic go_remote;
	logic go_local;

	// Operation test shared by the decode and every state group below except the output stage
	function automatic logic cmd_is(
		input ults_pkg::ults_cmd_t c,
		input ults_pkg::ults_cmd_op_t op
	);
		return c.valid && (c.op == op);
	endfunction : cmd_is

	always_comb begin
		por_done_d = 1'b1;
		// Commands count only once the power-on defaults are loaded
		cmd_live = por_done_q && cmd.valid;
		power_on = !por_done_q || cmd_is(cmd, ults_pkg::ULTS_CMD_POWER_ON);
		// Any command other than a remote-enable clear, in local mode with remote enabled, returns to remote
		go_remote = cmd_live && (mode_q == ults_pkg::ULTS_LOCAL) && ren_q;
		if (cmd_is(cmd, ults_pkg::ULTS_CMD_REMOTE_EN) && !cmd.flag) begin
			go_remote = 1'b0;
		end
		go_local = cmd_live && cmd_is(cmd, ults_pkg::ULTS_CMD_REMOTE_EN) && !cmd.flag;
		// The panel button is ignored under lockout or while a command is valid
		if (por_done_q && !cmd.valid && i_local_button && !i_local_lockout) begin
			go_local = 1'b1;
		end
	end

	// ****************************************
	// Mode state
	// ****************************************
	ults_pkg::ults_mode_t mode_d;
	logic ren_d;

	always_comb begin
		mode_d = mode_q;
		ren_d = ren_q;
		if (!por_done_q) begin
			// Start mode taken from the strap
			mode_d = i_power_on_remote ? ults_pkg::ULTS_REMOTE : ults_pkg::ULTS_LOCAL;
			ren_d = 1'b1;
		end else begin
			if (go_remote) begin
				mode_d = ults_pkg::ULTS_REMOTE;
			end
			if (go_local) begin
				mode_d = ults_pkg::ULTS_LOCAL;
			end
			if (cmd_is(cmd, ults_pkg::ULTS_CMD_REMOTE_EN)) begin
				ren_d = cmd.flag;
			end
			if (cmd_is(cmd, ults_pkg::ULTS_CMD_POWER_ON)) begin
				ren_d = 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_q <= ults_pkg::ULTS_LOCAL;
			ren_q <= 1'b1;
			por_done_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			ren_q <= ren_d;
			por_done_q <= por_done_d;
		end
	end

	// ****************************************
	// Output command state
	// ****************************************
	logic out_on_q;
	logic out_on_d;
	logic neg_q;
	logic neg_d;

	always_comb begin
		out_on_d = out_on_q;
		neg_d = neg_q;
		if (power_on) begin
			out_on_d = 1'b1;
			neg_d = 1'b0;
		end else if (cmd_live) begin
			if (go_remote) begin
				// Remote settings may differ from the panel's, so protect the load
				out_on_d = 1'b0;
			end
			if (cmd_is(cmd, ults_pkg::ULTS_CMD_OUTPUT)) begin
				out_on_d = cmd.flag;
			end
			if (cmd_is(cmd, ults_pkg::ULTS_CMD_VOLTAGE_SET)) begin
				neg_d = cmd.flag;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			out_on_q <= 1'b0;
			neg_q <= 1'b0;
		end else begin
			out_on_q <= out_on_d;
			neg_q <= neg_d;
		end
	end

	// ****************************************
	// Auxiliary line state
	// ****************************************
	logic aux_a_q;
	logic aux_a_d;
	logic aux_b_q;
	logic aux_b_d;

	always_comb begin
		aux_a_d = aux_a_q;
		aux_b_d = aux_b_q;
		if (power_on) begin
			aux_a_d = 1'b0;
			aux_b_d = 1'b0;
		end else begin
			if (cmd_is(cmd, ults_pkg::ULTS_CMD_AUX_A)) begin
				aux_a_d = cmd.flag;
			end
			if (cmd_is(cmd, ults_pkg::ULTS_CMD_AUX_B)) begin
				aux_b_d = cmd.flag;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			aux_a_q <= 1'b0;
			aux_b_q <= 1'b0;
		end else begin
			aux_a_q <= aux_a_d;
			aux_b_q <= aux_b_d;
		end
	end

	// ****************************************
	// Software trip level
	// ****************************************
	logic [ults_pkg::TRIP_W-1:0] sw_trip_q;
	logic [ults_pkg::TRIP_W-1:0] sw_trip_d;

	always_comb begin
		sw_trip_d = sw_trip_q;
		if (power_on) begin
			sw_trip_d = ults_pkg::ults_default_trip(i_rated_level);
		end else if (cmd_is(cmd, ults_pkg::ULTS_CMD_TRIP_LEVEL)) begin
			sw_trip_d = cmd.value;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sw_trip_q <= ults_pkg::RATED_LEVEL_DEF;
		end else begin
			sw_trip_q <= sw_trip_d;
		end
	end

	// ****************************************
	// Output stage
	// ****************************************
	logic sw_sel;
	logic shut_active;
	logic trip_sw_q;
	logic [ults_pkg::TRIP_W-1:0] trip_q;
	logic [ults_pkg::TRIP_W-1:0] trip_d;
	logic en_q;
	logic en_d;
	ults_pkg::ults_lines_t lines_q;
	ults_pkg::ults_lines_t lines_d;

	always_comb begin
		if (!i_jumpers.local_trip_jumper_closed) begin
			sw_sel = 1'b0;
		end else if (!i_jumpers.remote_trip_jumper_closed) begin
			sw_sel = 1'b1;
		end else begin
			sw_sel = (mode_q == ults_pkg::ULTS_REMOTE);
		end
		trip_d = sw_sel ? sw_trip_q : i_panel_trip_level;
		// Default polarity: high shuts down; alternate: low shuts down
		shut_active = i_jumpers.shutdown_polarity_alt ? !sync_q[1] : sync_q[1];
		// Shutdown only masks the output, command state stays intact
		en_d = out_on_q && !shut_active;
		lines_d.polarity = neg_q;
		lines_d.isolation = !out_on_q;
		lines_d.fault = |i_fault_bits;
		lines_d.aux_line_a = aux_a_q;
		lines_d.aux_line_b = aux_b_q;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trip_q <= '0;
			trip_sw_q <= 1'b0;
			en_q <= 1'b0;
			lines_q <= '0;
		end else begin
			trip_q <= trip_d;
			trip_sw_q <= sw_sel;
			en_q <= en_d;
			lines_q <= lines_d;
		end
	end

	// Open-collector lines never drive high
	always_comb begin
		o_remote_mode = (mode_q == ults_pkg::ULTS_REMOTE);
		o_over_voltage_trip = trip_q;
		o_trip_from_software = trip_sw_q;
		o_supply_output_en = en_q;
		o_output_cmd_on = out_on_q;
		o_lines_on = '0;
		o_lines_oe = lines_q;
	end

endmodule : ults_top

// File: hdl/ults_pkg.sv
// Package for the user lines and trip source select block
package ults_pkg;

	// ****************************************
	// Widths and defaults
	// ****************************************
	localparam int unsigned TRIP_W = 16;
	localparam int unsigned FAULT_W = 8;
	// Default software trip level is rated voltage times this percentage
	localparam int unsigned TRIP_DEFAULT_PCT = 110;
	localparam int unsigned PCT_DIV = 100;
	localparam logic [TRIP_W-1:0] RATED_LEVEL_DEF = 16'h0fa0;
	localparam logic [1:0] SYNC_RST = 2'h0;

	// ****************************************
	// Command carrier
	// ****************************************
	typedef enum logic [2:0] {
		ULTS_CMD_NONE,
		ULTS_CMD_TRIP_LEVEL,
		ULTS_CMD_VOLTAGE_SET,
		ULTS_CMD_OUTPUT,
		ULTS_CMD_AUX_A,
		ULTS_CMD_AUX_B,
		ULTS_CMD_REMOTE_EN,
		ULTS_CMD_POWER_ON
	} ults_cmd_op_t;

	typedef struct packed {
		logic valid;
		ults_cmd_op_t op;
		logic flag;
		logic [TRIP_W-1:0] value;
	} ults_cmd_t;

	typedef struct packed {
		logic local_trip_jumper_closed;
		logic remote_trip_jumper_closed;
		logic shutdown_polarity_alt;
	} ults_jumpers_t;

	typedef struct packed {
		logic polarity;
		logic isolation;
		logic fault;
		logic aux_line_a;
		logic aux_line_b;
	} ults_lines_t;

	typedef enum logic {
		ULTS_LOCAL,
		ULTS_REMOTE
	} ults_mode_t;

	function automatic logic [TRIP_W-1:0] ults_default_trip(input logic [TRIP_W-1:0] rated);
		logic [TRIP_W+7:0] prod;
		prod = {8'h00, rated} * (TRIP_W+8)'(TRIP_DEFAULT_PCT);
		return TRIP_W'(prod / (TRIP_W+8)'(PCT_DIV));
	endfunction : ults_default_trip

endpackage : ults_pkg

// File: dv/ults_properties.sv
// Port assertions for the user line block
module ults_properties (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire ults_pkg::ults_cmd_t i_serial_cmd,
	input wire ults_pkg::ults_cmd_t i_net_cmd,
	input wire ults_pkg::ults_jumpers_t i_jumpers,
	input wire logic [ults_pkg::FAULT_W-1:0] i_fault_bits,
	input wire logic i_shutdown_pin,
	input wire logic o_remote_mode,
	input wire logic o_trip_from_software,
	input wire logic o_supply_output_en,
	input wire logic o_output_cmd_on,
	input wire ults_pkg::ults_lines_t o_lines_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	logic [1:0] up_q;
	logic [1:0] up_d;
	wire ok = up_q == 2'h3;
	wire v = i_serial_cmd.valid;
	wire q = v || i_net_cmd.valid;
	wire [2:0] op = i_serial_cmd.op;
	wire f = i_serial_cmd.flag;
	wire lj = i_jumpers.local_trip_jumper_closed;
	wire rj = i_jumpers.remote_trip_jumper_closed;
	// Skips the edges that load the power-on defaults
	always_comb up_d = ok ? up_q : up_q + 2'h1;
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			up_q <= 2'h0;
		else
			up_q <= up_d;
	end
	a_fault_line: assert property ((ok && $stable(i_fault_bits))[*3] |-> o_lines_oe.fault == |i_fault_bits)
		else $error("fault line wrong");
	a_trip_source: assert property ((ok && $stable(o_remote_mode) && $stable(i_jumpers))[*2] |->
		o_trip_from_software == (lj && (o_remote_mode || !rj))) else $error("trip source wrong");
	a_isolation_line: assert property (ok |-> o_lines_oe.isolation == !$past(o_output_cmd_on))
		else $error("isolation line wrong");
	a_shutdown_gate: assert property ((ok && $stable(i_shutdown_pin) && $stable(o_output_cmd_on) &&
		$stable(i_jumpers))[*4] |-> o_supply_output_en == (o_output_cmd_on &&
		i_shutdown_pin == i_jumpers.shutdown_polarity_alt)) else $error("output gate wrong");
	a_polarity_line: assert property (ok && v && op == 3'h2 ##1 !q |-> ##1 o_lines_oe.polarity == $past(f, 2))
		else $error("polarity line wrong");
	a_aux_a_line: assert property (ok && v && op == 3'h4 ##1 !q |-> ##1 o_lines_oe.aux_line_a == $past(f, 2))
		else $error("aux line wrong");
	a_output_cmd: assert property (ok && v && op == 3'h3 |=> o_output_cmd_on == $past(f))
		else $error("output state wrong");
	a_remote_off: assert property (ok && v && op == 3'h6 && !f |=> !o_remote_mode)
		else $error("mode not local");
endmodule : ults_properties

bind ults_top ults_properties u_props (.i_sys_clk, .i_rst_b, .i_serial_cmd, .i_net_cmd, .i_jumpers, .i_fault_bits,
	.i_shutdown_pin, .o_remote_mode, .o_trip_from_software, .o_supply_output_en, .o_output_cmd_on, .o_lines_oe);

// File: dv/ults_user_ckt.sv
// Pull-up model of the external user circuit
module ults_user_ckt (
	input wire ults_pkg::ults_lines_t i_oe,
	input wire ults_pkg::ults_lines_t i_on,
	output logic [4:0] o_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// A driven line shows the pull-low value, a released one the pull-up
	assign o_level = ~i_oe | i_on;
endmodule : ults_user_ckt

// File: dv/tb.sv
// Self-checking bench for the user line block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic rst_b = 0;
	logic sd = 0;
	logic btn = 0;
	ults_pkg::ults_cmd_t scmd = '0;
	ults_pkg::ults_cmd_t ncmd = '0;
	ults_pkg::ults_jumpers_t jmp = 3'h6;
	logic [15:0] rated = 16'h0abc;
	logic [15:0] panel = 16'h0000;
	logic [15:0] sw;
	logic [15:0] trip;
	logic [7:0] fault = 8'h00;
	logic [3:0] s = 4'h4;
	logic rem, src, en, on;
	logic [4:0] lvl;
	ults_pkg::ults_lines_t oe, lon;
	int fail_count = 0;
	int n_tests = 0;
	initial forever #5 clk = ~clk;
	ults_top uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_serial_cmd(scmd), .i_net_cmd(ncmd), .i_jumpers(jmp),
		.i_power_on_remote(1'b1), .i_local_button(btn), .i_local_lockout(1'b0), .i_rated_level(rated),
		.i_panel_trip_level(panel), .i_fault_bits(fault), .i_shutdown_pin(sd), .o_remote_mode(rem),
		.o_over_voltage_trip(trip), .o_trip_from_software(src), .o_supply_output_en(en),
		.o_output_cmd_on(on), .o_lines_on(lon), .o_lines_oe(oe));
	ults_user_ckt u_ckt (.i_oe(oe), .i_on(lon), .o_level(lvl));
	function automatic logic [15:0] trip_def(input logic [15:0] r);
		return 16'((32'(r) * 110) / 100);
	endfunction : trip_def
	function automatic logic [4:0] exp_lines(input logic [3:0] st, input logic [7:0] fb);
		return ~{st[3], !st[2], |fb, st[1], st[0]};
	endfunction : exp_lines
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic send(input logic net, input logic [2:0] op, input logic fl, input logic [15:0] val);
		ults_pkg::ults_cmd_t c;
		c = {1'b1, op, fl, val};
		if (net)
			ncmd = c;
		else
			scmd = c;
		step(1);
		scmd = '0;
		ncmd = '0;
		step(1);
	endtask : send
	task automatic press();
		btn = 1;
		step(1);
		btn = 0;
		step(3);
	endtask : press
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		void'($urandom(27213));
		rated = $urandom;
		step(12);
		rst_b = 1;
		step(3);
		chk("default trip", trip_def(rated), trip);
		chk("lines", 5'h1f, lvl);
		chk("output", 1, en);
		sw = $urandom;
		send(0, 3'h1, 0, sw);
		for (int j = 0; j < 4; j++) begin
			jmp[2:1] = j[1:0];
			panel = $urandom;
			step(3);
			chk("trip remote", j[1] ? sw : panel, trip);
			press();
			chk("src local", j == 2, src);
			chk("trip local", (j == 2) ? sw : panel, trip);
			send(0, 3'h3, 1, 0);
		end
		press();
		send(1, 3'h5, 0, 0);
		chk("return", 2'h2, {rem, on});
		send(0, 3'h6, 0, 0);
		chk("ren off", 0, rem);
		send(0, 3'h6, 1, 0);
		send(0, 3'h3, 1, 0);
		for (int i = 0; i < 80; i++) begin
			int k;
			logic fl;
			k = $urandom % 4;
			fl = $urandom;
			fault = (i % 3 == 0) ? 8'h00 : 8'h01 << ($urandom % 8);
			jmp[0] = $urandom;
			sd = $urandom;
			s[3-k] = fl;
			send($urandom, 3'(k + 2), fl, $urandom);
			step(3);
			chk("lines", exp_lines(s, fault), lvl);
			chk("output", s[2] && (sd == jmp[0]), en);
		end
		rated = $urandom;
		send(0, 3'h7, 0, 0);
		chk("power-on trip", trip_def(rated), trip);
		chk("power-on lines", exp_lines(4'h4, fault), lvl);
		chk("power-on output", sd == jmp[0], en);
		tally_and_finish();
	end
endmodule : tb
